// *** hdl/cpg_pkg.sv ***
// Package for the continuous pointer and frequency offset generator.
// Assumes a 100 MHz system clock and a one-cycle frame strobe every 125 us.
package cpg_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int FRAME_US      = 125;
  localparam int FRAMES_PER_MS = 1000 / FRAME_US;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_USERMS = 8'h04;
  localparam logic [7:0] ADDR_OFSEDT = 8'h08;
  localparam logic [7:0] ADDR_PTR    = 8'h0C;
  localparam logic [7:0] ADDR_REPORT = 8'h10;

  localparam int CTRL_ENABLE    = 0;
  localparam int CTRL_MODE      = 1;
  localparam int CTRL_DIR_LSB   = 2;
  localparam int CTRL_RATE_LSB  = 4;
  localparam int CTRL_VTTYPE    = 7;
  localparam int CTRL_VTASYNC   = 8;
  localparam int CTRL_OMODE_LSB = 9;
  localparam int CTRL_OSEL_LSB  = 11;
  localparam int CTRL_WIDTH     = 14;

  localparam int EDIT_FINE_UP   = 0;
  localparam int EDIT_FINE_DN   = 1;
  localparam int EDIT_COARSE_UP = 2;
  localparam int EDIT_COARSE_DN = 3;

  localparam int REP_VALID = 31;
  localparam int REP_NONE  = 30;

  typedef enum logic [1:0] {
    CPG_DIR_INC = 2'h0,
    CPG_DIR_DEC = 2'h1,
    CPG_DIR_ALT = 2'h2
  } cpg_dir_t;

  typedef enum logic [2:0] {
    CPG_RATE_DEF50  = 3'h0,
    CPG_RATE_MAX2   = 3'h1,
    CPG_RATE_MIN10K = 3'h2,
    CPG_RATE_MAX48  = 3'h3,
    CPG_RATE_USER   = 3'h4
  } cpg_rate_t;

  typedef enum logic [2:0] {
    CPG_OFS_ZERO  = 3'h0,
    CPG_OFS_MAX   = 3'h1,
    CPG_OFS_STRP  = 3'h2,
    CPG_OFS_STRN  = 3'h3,
    CPG_OFS_USER  = 3'h4
  } cpg_osel_t;

  // Interval presets in milliseconds.
  localparam logic [13:0] RATE_DEF_MS   = 14'h0032;
  localparam logic [13:0] RATE_MAX2_MS  = 14'h0002;
  localparam logic [13:0] RATE_MIN_MS   = 14'h2710;
  localparam logic [13:0] RATE_MAX48_MS = 14'h0030;
  localparam logic [13:0] USER_MS_MIN   = 14'h0001;
  localparam logic [13:0] USER_MS_MAX   = 14'h2710;

  // Offsets are held in tenths of a ppm.
  localparam logic signed [11:0] OFS_MAX    = 12'sh3E8;
  localparam logic signed [11:0] OFS_STRESS = 12'sh02E;
  localparam logic signed [11:0] OFS_FINE   = 12'sh001;
  localparam logic signed [11:0] OFS_COARSE = 12'sh064;
  localparam logic signed [11:0] OFS_LIMIT  = 12'sh3E8;

  localparam logic [9:0] STS_PTR_MAX = 10'h30E;
  localparam logic [9:0] VT_PTR_MAX  = 10'h067;
  localparam logic [9:0] STS_PTR_RST = 10'h20A;
  localparam logic [9:0] VT_PTR_RST  = 10'h04E;

  // Offset tenths-ppm summed per frame that equal one pointer location.
  localparam logic [17:0] STS_LOC_UNITS = 18'h031E3;
  localparam logic [17:0] VT_LOC_UNITS  = 18'h177A6;

  // Conversion constant: tenths-ppm times milliseconds for one location per interval.
  localparam logic [15:0] STS_CONV_K = 16'h063C;
  localparam logic [15:0] VT_CONV_K  = 16'hBBCD;
  localparam int          DIV_BITS   = 16;

  typedef struct packed {
    logic       valid;
    logic       inc;
    logic [9:0] value;
  } cpg_adj_t;

endpackage : cpg_pkg

// *** hdl/cpg_pointer_gen.sv ***
// Continuous pointer movement and frequency offset generator, transmit side.
// Assumes frameTick pulses once per transmitted frame, synchronous to clk.
//
// Notes on behaviour
// - 48 ms preset only with VT1.5 async.
// - 2 ms preset moves every sixteen frames.
// - Slowest preset moves every ten seconds.
// - Default interval is 50 ms.
// - User interval 1 to 10000 ms, 1 ms.
// - Increment direction raises pointer each interval.
// - Decrement direction lowers pointer each interval.
// - Alternate direction toggles between up and down.
// - Fixed direction reports equivalent ppm; alternate none.
// - Offset applies to payload, line, or both.
// - Line offset leaves pointer location unmoved.
// - Payload offset produces pointer adjustments.
// - Maximum offset preset is plus 100 ppm.
// - Stress presets plus and minus 4.6 ppm.
// - Default offset preset is zero, disabled.
// - Coarse edit step is 10.0 ppm.
// - Fine edit step is 0.1 ppm.
// - User offset limited to plus/minus 100 ppm.
// - Active payload offset reports equivalent pointer interval; line-only offset reports none.
// - STS pointer 0..782, VT pointer 0..103.
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
module cpg_pointer_gen
  import cpg_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               frameTick,
  input  wire logic [7:0]         busAddr,
  input  wire logic [31:0]        busWdata,
  input  wire logic               busWrite,
  input  wire logic               busRead,
  output logic      [31:0]        busRdata,
  output cpg_adj_t                ptrAdj,
  output logic signed [11:0]      lineOffset,
  output logic signed [11:0]      payloadOffset
);

  typedef enum logic [1:0] {
    DIV_IDLE = 2'b01,
    DIV_RUN  = 2'b10
  } cpg_div_state_t;

  logic [CTRL_WIDTH-1:0] ctrl_q;
  logic [13:0]           userMs_q;
  logic signed [11:0]    userOfs_q;
  logic signed [11:0]    userOfs_d;
  logic [9:0]            ptr_q;
  logic                  altUp_q;
  logic [16:0]           frameCnt_q;
  logic [17:0]           accum_q;
  cpg_adj_t              adj_q;
  logic [31:0]           rdata_q;
  logic [31:0]           report_q;

  logic                  enable;
  logic                  freqMode;
  cpg_dir_t              dir;
  cpg_rate_t             rateSel;
  logic                  vtType;
  logic                  vtAsync;
  logic [1:0]            offsetMode;
  cpg_osel_t             offsetSel;
  logic [13:0]           intervalMs;
  logic [16:0]           intervalFrames;
  logic signed [11:0]    activeOfs;
  logic [11:0]           absOfs;
  logic [9:0]            ptrMax;
  logic [17:0]           locUnits;
  logic                  payloadOn;
  logic                  contStep;
  logic                  ofsStep;
  logic                  stepInc;

  assign enable     = ctrl_q[CTRL_ENABLE];
  assign freqMode   = ctrl_q[CTRL_MODE];
  assign dir        = cpg_dir_t'(ctrl_q[CTRL_DIR_LSB +: 2]);
  assign rateSel    = cpg_rate_t'(ctrl_q[CTRL_RATE_LSB +: 3]);
  assign vtType     = ctrl_q[CTRL_VTTYPE];
  assign vtAsync    = ctrl_q[CTRL_VTASYNC];
  assign offsetMode = ctrl_q[CTRL_OMODE_LSB +: 2];
  assign offsetSel  = cpg_osel_t'(ctrl_q[CTRL_OSEL_LSB +: 3]);

  assign ptrMax   = vtType ? VT_PTR_MAX : STS_PTR_MAX;
  assign locUnits = vtType ? VT_LOC_UNITS : STS_LOC_UNITS;

  // Interval selection; an unavailable 48 ms choice falls back to the default.
  always_comb begin
    unique case (rateSel)
      CPG_RATE_MAX2:   intervalMs = RATE_MAX2_MS;
      CPG_RATE_MIN10K: intervalMs = RATE_MIN_MS;
      CPG_RATE_MAX48:  intervalMs = (vtType && vtAsync) ? RATE_MAX48_MS : RATE_DEF_MS;
      // User value, already clamped on write.
      CPG_RATE_USER:   intervalMs = userMs_q;
      default:         intervalMs = RATE_DEF_MS;
    endcase
  end

  assign intervalFrames = {3'h0, intervalMs} * 17'(FRAMES_PER_MS);

  // Offset preset selection.
  always_comb begin
    unique case (offsetSel)
      CPG_OFS_MAX:  activeOfs = OFS_MAX;
      CPG_OFS_STRP: activeOfs = OFS_STRESS;
      CPG_OFS_STRN: activeOfs = -OFS_STRESS;
      CPG_OFS_USER: activeOfs = userOfs_q;
      default:      activeOfs = '0;
    endcase
  end

  assign absOfs = activeOfs[11] ? 12'(-activeOfs) : 12'(activeOfs);

  // Offsets go to the line, the payload, or both.
  assign payloadOn = enable && freqMode && offsetMode[1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lineOffset    <= '0;
      payloadOffset <= '0;
    end else begin
      lineOffset    <= (enable && freqMode && offsetMode[0]) ? activeOfs : 12'sh000;
      payloadOffset <= payloadOn ? activeOfs : 12'sh000;
    end
  end

  // Interval timer in frames; the step lands on the frame strobe.
  assign contStep = enable && !freqMode && frameTick && (frameCnt_q >= intervalFrames - 17'h1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frameCnt_q <= '0;
    end else if (!enable || freqMode) begin
      frameCnt_q <= '0;
    end else if (frameTick) begin
      frameCnt_q <= contStep ? 17'h0 : frameCnt_q + 17'h1;
    end
  end

  // Payload offset drift accumulates per frame into pointer steps.
  // A line-only offset never reaches this accumulator.
  assign ofsStep = payloadOn && frameTick && (accum_q + {6'h0, absOfs} >= locUnits);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accum_q <= '0;
    end else if (!payloadOn || absOfs == 12'h000) begin
      accum_q <= '0;
    end else if (frameTick) begin
      accum_q <= ofsStep ? accum_q + {6'h0, absOfs} - locUnits
                         : accum_q + {6'h0, absOfs};
    end
  end

  // A faster payload is shed by negative justification, so the pointer falls.
  always_comb begin
    if (ofsStep) begin
      stepInc = activeOfs[11];
    end else begin
      unique case (dir)
        CPG_DIR_INC: stepInc = 1'b1;
        CPG_DIR_DEC: stepInc = 1'b0;
        default:     stepInc = altUp_q;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      altUp_q <= 1'b1;
    end else if (contStep && dir == CPG_DIR_ALT) begin
      altUp_q <= !altUp_q;
    end
  end

  // Pointer value and adjustment strobe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= STS_PTR_RST;
      adj_q <= '0;
    end else begin
      adj_q.valid <= contStep || ofsStep;
      if (busWrite && busAddr == ADDR_PTR) begin
        ptr_q <= (busWdata[9:0] > ptrMax) ? ptrMax : busWdata[9:0];
      end else if (busWrite && busAddr == ADDR_CTRL
                   && busWdata[CTRL_VTTYPE] != ctrl_q[CTRL_VTTYPE]) begin
        ptr_q <= busWdata[CTRL_VTTYPE] ? VT_PTR_RST : STS_PTR_RST;
      end else if (contStep || ofsStep) begin
        adj_q.inc <= stepInc;
        // Wrap at both ends of the range.
        if (stepInc) begin
          ptr_q <= (ptr_q >= ptrMax) ? 10'h000 : ptr_q + 10'h001;
        end else begin
          ptr_q <= (ptr_q == 10'h000) ? ptrMax : ptr_q - 10'h001;
        end
      end
      adj_q.value <= ptr_q;
    end
  end

  assign ptrAdj = '{valid: adj_q.valid, inc: adj_q.inc, value: ptr_q};

  // Register writes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= '0;
      userMs_q <= RATE_DEF_MS;
    end else if (busWrite) begin
      if (busAddr == ADDR_CTRL) begin
        ctrl_q <= busWdata[CTRL_WIDTH-1:0];
      end
      if (busAddr == ADDR_USERMS) begin
        if (busWdata[31:0] < {18'h0, USER_MS_MIN}) begin
          userMs_q <= USER_MS_MIN;
        end else if (busWdata[31:0] > {18'h0, USER_MS_MAX}) begin
          userMs_q <= USER_MS_MAX;
        end else begin
          userMs_q <= busWdata[13:0];
        end
      end
    end
  end

  // User offset edit steps with saturation.
  always_comb begin
    userOfs_d = userOfs_q;
    if (busWdata[EDIT_FINE_UP]) begin
      userOfs_d = userOfs_d + OFS_FINE;
    end
    if (busWdata[EDIT_FINE_DN]) begin
      userOfs_d = userOfs_d - OFS_FINE;
    end
    if (busWdata[EDIT_COARSE_UP]) begin
      userOfs_d = userOfs_d + OFS_COARSE;
    end
    if (busWdata[EDIT_COARSE_DN]) begin
      userOfs_d = userOfs_d - OFS_COARSE;
    end
    // Saturate at the limits; the 12-bit sum cannot overflow from inside them.
    if (userOfs_d > OFS_LIMIT) begin
      userOfs_d = OFS_LIMIT;
    end else if (userOfs_d < -OFS_LIMIT) begin
      userOfs_d = -OFS_LIMIT;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      userOfs_q <= '0;
    end else if (busWrite && busAddr == ADDR_OFSEDT) begin
      userOfs_q <= userOfs_d;
    end
  end

  // Equivalence report. One restoring divider serves both directions:
  // ppm tenths = K / interval ms, and interval ms = K / offset tenths.
  cpg_div_state_t      divState_q;
  logic [15:0]         divQuot_q;
  logic [15:0]         divNum_q;
  logic [16:0]         divRem_q;
  logic [13:0]         divDen_q;
  logic [4:0]          divCnt_q;
  logic                divNone_q;
  logic [13:0]         divDen;
  logic                reportNone;
  logic [16:0]         remShift;

  // Alternate direction has no equivalent offset.
  // Offset mode reports the resulting interval; zero or line-only offset gives none.
  always_comb begin
    if (freqMode) begin
      divDen     = {2'h0, absOfs};
      reportNone = !offsetMode[1] || absOfs == 12'h000;
    end else begin
      divDen     = intervalMs;
      reportNone = dir == CPG_DIR_ALT;
    end
  end

  assign remShift = {divRem_q[15:0], divNum_q[DIV_BITS-1]};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divState_q <= DIV_IDLE;
      divQuot_q  <= '0;
      divNum_q   <= '0;
      divRem_q   <= '0;
      divDen_q   <= '0;
      divCnt_q   <= '0;
      divNone_q  <= 1'b1;
      report_q   <= '0;
    end else begin
      unique case (divState_q)
        DIV_IDLE: begin
          divNum_q   <= vtType ? VT_CONV_K : STS_CONV_K;
          divDen_q   <= divDen;
          divNone_q  <= reportNone || !enable;
          divRem_q   <= '0;
          divQuot_q  <= '0;
          divCnt_q   <= 5'(DIV_BITS);
          divState_q <= DIV_RUN;
        end
        DIV_RUN: begin
          divNum_q <= {divNum_q[DIV_BITS-2:0], 1'b0};
          if (remShift >= {3'h0, divDen_q}) begin
            divRem_q  <= remShift - {3'h0, divDen_q};
            divQuot_q <= {divQuot_q[14:0], 1'b1};
          end else begin
            divRem_q  <= remShift;
            divQuot_q <= {divQuot_q[14:0], 1'b0};
          end
          divCnt_q <= divCnt_q - 5'h01;
          if (divCnt_q == 5'h01) begin
            divState_q <= DIV_IDLE;
            report_q   <= '0;
            if (divNone_q) begin
              report_q[REP_NONE] <= 1'b1;
            end else begin
              report_q[REP_VALID] <= 1'b1;
              report_q[15:0]      <= remShift >= {3'h0, divDen_q}
                                     ? {divQuot_q[14:0], 1'b1}
                                     : {divQuot_q[14:0], 1'b0};
            end
          end
        end
      endcase
    end
  end

  // Register reads answer in the following cycle; unmapped addresses read zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (busRead) begin
      unique case (busAddr)
        ADDR_CTRL:   rdata_q <= {{(32-CTRL_WIDTH){1'b0}}, ctrl_q};
        ADDR_USERMS: rdata_q <= {18'h0, userMs_q};
        ADDR_OFSEDT: rdata_q <= {{20{userOfs_q[11]}}, userOfs_q};
        ADDR_PTR:    rdata_q <= {22'h0, ptr_q};
        ADDR_REPORT: rdata_q <= report_q;
        default:     rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign busRdata = rdata_q;

endmodule : cpg_pointer_gen

// *** tb/cpg_pointer_gen_monitor.sv ***
// Port checker for the pointer generator.
// Assumes frameTick pulses no closer than every second cycle.
`timescale 1ns/1ps
module cpg_pointer_gen_monitor
  import cpg_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               frameTick,
  input wire logic [7:0]         busAddr,
  input wire logic [31:0]        busWdata,
  input wire logic               busWrite,
  input wire logic               busRead,
  input wire logic [31:0]        busRdata,
  input wire cpg_adj_t           ptrAdj,
  input wire logic signed [11:0] lineOffset,
  input wire logic signed [11:0] payloadOffset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] ticks_q;
  // Frames since the last adjustment, saturating so long gaps stay legal.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ticks_q <= 8'h00;
    else if (ptrAdj.valid) ticks_q <= 8'h00;
    else if (frameTick && ticks_q != 8'hFF) ticks_q <= ticks_q + 8'h01;
  end
  property p_at_frame; ptrAdj.valid |-> $past(frameTick); endproperty
  a_at_frame: assert property (p_at_frame) else $error("adjust not at frame");
  property p_pulse; ptrAdj.valid |=> !ptrAdj.valid; endproperty
  a_pulse: assert property (p_pulse) else $error("adjust pulse too long");
  property p_gap; ptrAdj.valid |-> ticks_q >= 8'h08; endproperty
  a_gap: assert property (p_gap) else $error("adjust gap under 1 ms");
  property p_range; ptrAdj.value <= STS_PTR_MAX; endproperty
  a_range: assert property (p_range) else $error("pointer out of range");
  property p_inc;
    ptrAdj.valid && ptrAdj.inc && $past(ptrAdj.value) != VT_PTR_MAX
      && $past(ptrAdj.value) != STS_PTR_MAX
      |-> ptrAdj.value == $past(ptrAdj.value) + 10'h001;
  endproperty
  a_inc: assert property (p_inc) else $error("increment step wrong");
  property p_dec;
    ptrAdj.valid && !ptrAdj.inc && $past(ptrAdj.value) != 10'h000
      |-> ptrAdj.value == $past(ptrAdj.value) - 10'h001;
  endproperty
  a_dec: assert property (p_dec) else $error("decrement step wrong");
  property p_wrap_up;
    ptrAdj.valid && ptrAdj.inc && $past(ptrAdj.value) == STS_PTR_MAX |-> ptrAdj.value == 10'h000;
  endproperty
  a_wrap_up: assert property (p_wrap_up) else $error("no wrap to zero");
  property p_wrap_dn;
    ptrAdj.valid && !ptrAdj.inc && $past(ptrAdj.value) == 10'h000
      |-> ptrAdj.value == STS_PTR_MAX || ptrAdj.value == VT_PTR_MAX;
  endproperty
  a_wrap_dn: assert property (p_wrap_dn) else $error("no wrap to max");
  property p_pay_lim; payloadOffset <= OFS_LIMIT && payloadOffset >= -OFS_LIMIT; endproperty
  a_pay_lim: assert property (p_pay_lim) else $error("payload offset too big");
  property p_line_lim; lineOffset <= OFS_MAX && lineOffset >= -OFS_MAX; endproperty
  a_line_lim: assert property (p_line_lim) else $error("line offset too big");
  c_up: cover property (ptrAdj.valid && ptrAdj.inc);
  c_dn: cover property (ptrAdj.valid && !ptrAdj.inc);
  c_line: cover property (lineOffset != 12'sh000);
endmodule : cpg_pointer_gen_monitor
bind cpg_pointer_gen cpg_pointer_gen_monitor cpg_pointer_gen_monitor_i (.clk(clk), .rst_n(rst_n),
  .frameTick(frameTick), .busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite),
  .busRead(busRead), .busRdata(busRdata), .ptrAdj(ptrAdj), .lineOffset(lineOffset),
  .payloadOffset(payloadOffset));

// *** tb/cpg_frame_sink.sv ***
// Receiving network element with its transmit frame clock.
// Assumes one clock; frames are shortened to FRAME_CYC cycles to keep runs short.
`timescale 1ns/1ps
module cpg_frame_sink
  import cpg_pkg::*;
#(parameter int FRAME_CYC = 4)
(
  input  wire logic     clk,
  input  wire logic     rst_n,
  input  wire cpg_adj_t ptrAdj,
  output logic          frameTick,
  output int            adjCount,
  output int            badCount
);
  int phase;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 0;
      frameTick <= 1'b0;
    end else begin
      phase <= (phase == FRAME_CYC - 1) ? 0 : phase + 1;
      frameTick <= (phase == FRAME_CYC - 1);
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adjCount <= 0;
      badCount <= 0;
    end else if (ptrAdj.valid) begin
      adjCount <= adjCount + 1;
      if (ptrAdj.value > STS_PTR_MAX) badCount <= badCount + 1;
    end
  end
endmodule : cpg_frame_sink

// *** tb/cpg_pointer_gen_bench.sv ***
// Self-checking bench for the pointer generator and its receiving model.
// Assumes four-cycle frames, so an interval of N ms is 8N frame ticks.
`timescale 1ns/1ps
module cpg_pointer_gen_bench
  import cpg_pkg::*;
;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic [7:0]         busAddr = 8'h00;
  logic [31:0]        busWdata = 32'h0;
  logic               busWrite = 1'b0;
  logic               busRead = 1'b0;
  logic [31:0]        busRdata;
  cpg_adj_t           ptrAdj;
  logic signed [11:0] lineOffset;
  logic signed [11:0] payloadOffset;
  logic               frameTick;
  logic [31:0]        d;
  int                 adjCount, badCount, errors = 0, checked = 0, n, p, e, k, ms;
  int                 ofsExp[4] = '{0, 1000, 46, -46};
  always #5 clk = ~clk;
  cpg_pointer_gen cpg_pointer_gen_i (.clk(clk), .rst_n(rst_n), .frameTick(frameTick),
    .busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite), .busRead(busRead),
    .busRdata(busRdata), .ptrAdj(ptrAdj), .lineOffset(lineOffset),
    .payloadOffset(payloadOffset));
  cpg_frame_sink #(.FRAME_CYC(4)) cpg_frame_sink_i (.clk(clk), .rst_n(rst_n),
    .ptrAdj(ptrAdj), .frameTick(frameTick), .adjCount(adjCount), .badCount(badCount));
  function automatic logic [31:0] ctl(logic [1:0] dir, logic [2:0] rate, logic [1:0] vt,
                                      logic [1:0] om, logic [2:0] os, logic fm);
    return {18'h0, os, om, vt, rate, dir, fm, 1'b1};
  endfunction : ctl
  function automatic logic [31:0] rep(int kk, int mm);
    return 32'h80000000 | 32'(kk / mm);
  endfunction : rep
  function automatic int sat(int v);
    return v > OFS_LIMIT ? int'(OFS_LIMIT) : (v < -OFS_LIMIT ? -int'(OFS_LIMIT) : v);
  endfunction : sat
  task automatic summarize();
    $display("errors %0d, checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    busAddr <= a;
    busWdata <= v;
    busWrite <= 1'b1;
    @(posedge clk);
    busWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    busAddr <= a;
    busRead <= 1'b1;
    @(posedge clk);
    busRead <= 1'b0;
    #1 v = busRdata;
  endtask : rd
  task automatic chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    cmp(v, exp);
  endtask : chk
  // Counts frame ticks until the next adjustment; -1 if none comes.
  task automatic waitAdj(output int f);
    f = 0;
    repeat (5000) begin
      @(negedge clk);
      if (ptrAdj.valid === 1'b1) return;
      if (frameTick === 1'b1) f++;
    end
    f = -1;
  endtask : waitAdj
  task automatic meas(input logic [31:0] c, input int f, input int v);
    int m;
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, c);
    waitAdj(m);
    cmp(m, f);
    cmp(ptrAdj.value, v);
  endtask : meas
  initial begin
    #300_000;
    errors++;
    summarize();
  end
  initial begin
    void'($urandom(35));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    chk(ADDR_CTRL, 32'h0);
    chk(ADDR_USERMS, 32'h32);
    chk(ADDR_PTR, 32'h20A);
    chk(8'h14, 32'h0);
    meas(ctl(0, 1, 0, 0, 0, 0), 16, 523);
    chk(ADDR_REPORT, rep(STS_CONV_K, 2));
    meas(ctl(0, 0, 0, 0, 0, 0), 400, 524);
    chk(ADDR_REPORT, rep(STS_CONV_K, 50));
    meas(ctl(0, 3, 3, 0, 0, 0), 384, 79);
    chk(ADDR_REPORT, rep(VT_CONV_K, 48));
    meas(ctl(0, 3, 0, 0, 0, 0), 400, 523);
    chk(ADDR_REPORT, rep(STS_CONV_K, 10000 / 10000 * 50));
    wr(ADDR_USERMS, 32'h0);
    chk(ADDR_USERMS, 32'h1);
    wr(ADDR_USERMS, 32'h4E20);
    chk(ADDR_USERMS, 32'h2710);
    wr(ADDR_CTRL, ctl(0, 2, 0, 0, 0, 0));
    repeat (40) @(posedge clk);
    chk(ADDR_REPORT, rep(STS_CONV_K, 10000));
    p = 523;
    for (int i = 0; i < 3; i++) begin
      ms = (i == 0) ? 1 : $urandom_range(2, 6);
      wr(ADDR_USERMS, 32'(ms));
      p++;
      meas(ctl(0, 4, 0, 0, 0, 0), ms * FRAMES_PER_MS, p);
    end
    wr(ADDR_PTR, 32'h0);
    meas(ctl(1, 1, 0, 0, 0, 0), 16, STS_PTR_MAX);
    meas(ctl(0, 1, 0, 0, 0, 0), 16, 0);
    wr(ADDR_PTR, 32'h64);
    meas(ctl(2, 1, 0, 0, 0, 0), 16, 101);
    waitAdj(n);
    cmp(n, 16);
    cmp(ptrAdj.value, 100);
    rd(ADDR_REPORT, d);
    cmp(d[REP_NONE], 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, ctl(0, 0, 0, 2, 3'(i), 1));
      repeat (40) @(posedge clk);
      cmp(32'(payloadOffset), 32'(ofsExp[i]));
      cmp(32'(lineOffset), 32'h0);
    end
    wr(ADDR_CTRL, ctl(0, 0, 0, 1, 1, 1));
    repeat (40) @(posedge clk);
    cmp(32'(lineOffset), 32'(1000));
    cmp(32'(payloadOffset), 32'h0);
    n = adjCount;
    repeat (400) @(posedge clk);
    cmp(adjCount, n);
    wr(ADDR_CTRL, ctl(0, 0, 0, 3, 1, 1));
    repeat (40) @(posedge clk);
    cmp(32'(lineOffset + payloadOffset), 32'(2000));
    for (int i = 1; i < 4; i += 2) begin
      wr(ADDR_CTRL, ctl(0, 0, 0, 2, 3'(i), 1));
      waitAdj(n);
      waitAdj(n);
      // The gap depends on the offset's size only, so take its magnitude first.
      k = ofsExp[i] < 0 ? -ofsExp[i] : ofsExp[i];
      ms = int'(STS_LOC_UNITS);
      cmp(n >= ms / k && n <= (ms + k - 1) / k, 1);
      cmp(ptrAdj.inc, ofsExp[i] < 0);
      chk(ADDR_REPORT, rep(STS_CONV_K, k));
    end
    wr(ADDR_CTRL, ctl(0, 0, 0, 2, 4, 1));
    repeat (11) wr(ADDR_OFSEDT, 32'h4);
    wr(ADDR_OFSEDT, 32'h1);
    chk(ADDR_OFSEDT, 32'(1000));
    wr(ADDR_OFSEDT, 32'h2);
    chk(ADDR_OFSEDT, 32'(999));
    repeat (10) wr(ADDR_OFSEDT, 32'h8);
    e = -1;
    repeat (9) begin
      k = $urandom_range(0, 15);
      e = sat(e + k[0] - k[1] + 100 * (k[2] - k[3]));
      wr(ADDR_OFSEDT, 32'(k));
      chk(ADDR_OFSEDT, 32'(e));
    end
    repeat (40) @(posedge clk);
    cmp(32'(payloadOffset), 32'(e));
    cmp(badCount, 0);
    summarize();
  end
endmodule : cpg_pointer_gen_bench
